// File: logic/fsp_top.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] Completing a write-lock command clears the write-enable latch.
// [RULE_02] Host sends write-lock as one command byte framed by chip select.
// [RULE_03] Latch clears at reset and after lock, status write, program, erase commands.
// [RULE_04] Identity read returns manufacturer, memory-type, then capacity byte.
// [RULE_05] Identity bits leave on serial output, changing on falling clock edges.
// [RULE_06] Identity read is ignored while a program or erase cycle runs.
// [RULE_07] Raising chip select ends identity read anytime; device returns to standby.
// [RULE_08] Status read works anytime and repeats the status byte while clocked.
// [RULE_09] Host should poll the busy flag during internal cycles.
// [RULE_10] Busy flag is 1 during status-write, program or erase cycles.
// [RULE_11] Write-enable flag mirrors the latch; clear latch refuses all write commands.
// [RULE_12] Protect-level bits persist, change only by status write, guard selected area; here reset also loads them with NV_PROT_RST (0).
// [RULE_13] Bulk erase runs only when all protect-level bits are zero.
// [RULE_14] Lock bit set with protect pin low makes status bits read-only.
// [RULE_15] Status write needs the latch set by an earlier write-unlock command.
// [RULE_16] Status write is code plus one byte, select raised right after.
// [RULE_17] Status write leaves b6,b5,b1,b0; b6 and b5 read zero.
// [RULE_18] Valid status write starts timed cycle; busy throughout; latch clears at end.
// [RULE_19] With lock bit clear, status byte is writable whenever latch is set.
// [RULE_20] Hardware lock holds whichever of lock bit or pin low comes first.
// [RULE_21] Hardware lock leaves only when the protect pin returns high.
// [RULE_22] In hardware lock the protected area stays protected, bits being frozen.
// [RULE_23] Codes: 06h unlock, 04h lock, 9Fh identity, 05h status read, 01h write.
// [RULE_24] Bits travel MSB first, inputs sampled on rising serial clock edges.
// [RULE_25] Write-unlock sets the latch; write commands ending off a byte are rejected.
// [RULE_26] Status byte: lock b7, protect-level b4..b2, latch b1, busy b0.
module fsp_top #(
    parameter logic [23:0] ID_WORD = 24'h5a3ca5, // Arbitrary identification value
    parameter int unsigned STATUS_WRITE_CYC = fsp_pkg::STATUS_WRITE_CYCLES,
    parameter int unsigned PAGE_PROGRAM_CYC = fsp_pkg::PAGE_PROGRAM_CYCLES,
    parameter int unsigned SECTOR_ERASE_CYC = fsp_pkg::SECTOR_ERASE_CYCLES,
    parameter int unsigned BULK_ERASE_CYC = fsp_pkg::BULK_ERASE_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_spi_clk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_d,
    input wire logic i_wp_n,
    output logic o_spi_q,
    output logic o_spi_q_oe_n,
    output logic [7:0] o_status_byte
);
    import fsp_pkg::*;

    // Link side, rising edge, cleared whenever the device is deselected
    typedef struct packed {
        logic [2:0] bit_idx;
        logic [2:0] byte_cnt;
        logic [7:0] shift;
        fsp_out_e mode;
    } fsp_frame_s;

    // Link side, rising edge, survives deselect so the system side can read it
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] wdata;
        logic [23:0] addr;
        logic [2:0] bytes;
        logic aligned;
        logic tog;
    } fsp_cap_s;

    // Link side, falling edge
    typedef struct packed {
        logic q;
        logic oe_n;
    } fsp_out_s;

    // System side
    typedef struct packed {
        fsp_sys_e state;
        logic write_enable_latch;
        logic lock;
        logic [2:0] prot;
        logic pend_status;
        logic pend_lock;
        logic [2:0] pend_prot;
        logic [31:0] timer;
        logic cs_prev;
        logic tog_seen;
        logic [7:0] status;
    } fsp_sys_s;

    fsp_frame_s frame_reg;
    fsp_frame_s frame_next;
    fsp_cap_s cap_reg;
    fsp_cap_s cap_next;
    fsp_out_s out_reg;
    fsp_out_s out_next;
    fsp_sys_s sys_reg;
    fsp_sys_s sys_next;

    logic link_rst;
    logic [7:0] status_link;
    logic cs_sys;
    logic tog_sys;
    logic wp_sys;

    assign link_rst = i_sys_rst | i_spi_cs_n;

    fsp_sync #(
        .WIDTH(8)
    ) u_status_to_link (
        .i_clk(i_spi_clk),
        .i_rst(i_sys_rst),
        .i_d(sys_reg.status),
        .o_q(status_link)
    );

    fsp_sync #(
        .WIDTH(3)
    ) u_link_to_sys (
        .i_clk(i_clk_sys),
        .i_rst(i_sys_rst),
        .i_d({i_spi_cs_n, cap_reg.tog, i_wp_n}),
        .o_q({cs_sys, tog_sys, wp_sys})
    );

    // Serial input: shift, count bits and bytes, pick the output mode
    always_comb begin
        logic [7:0] shifted;
        shifted = {frame_reg.shift[6:0], i_spi_d}; // [RULE_24]
        frame_next = frame_reg;
        cap_next = cap_reg;
        frame_next.shift = shifted;
        frame_next.bit_idx = frame_reg.bit_idx + 3'h1;
        if (frame_reg.bit_idx == 3'h7 && frame_reg.byte_cnt != BYTES_SAT) begin
            frame_next.byte_cnt = frame_reg.byte_cnt + 3'h1;
        end
        if (frame_reg.bit_idx == 3'h7 && frame_reg.byte_cnt == 3'h0) begin
            if (shifted == CMD_STATUS_READ) begin
                frame_next.mode = OUT_STATUS; // [RULE_08] [RULE_23]
            end else if (shifted == CMD_IDENTITY_READ && !status_link[ST_BUSY_BIT]) begin
                frame_next.mode = OUT_IDENT; // [RULE_06] [RULE_23]
            end else begin
                frame_next.mode = OUT_NONE;
            end
        end
        if (frame_reg.bit_idx == 3'h0 && frame_reg.byte_cnt == 3'h0) begin
            cap_next.tog = ~cap_reg.tog;
        end
        cap_next.bytes = frame_next.byte_cnt;
        cap_next.aligned = (frame_next.bit_idx == 3'h0); // [RULE_25]
        if (frame_reg.bit_idx == 3'h7) begin
            unique case (frame_reg.byte_cnt)
                3'h0: cap_next.cmd = shifted;
                3'h1: begin
                    cap_next.wdata = shifted;
                    cap_next.addr[23:16] = shifted;
                end
                3'h2: cap_next.addr[15:8] = shifted;
                3'h3: cap_next.addr[7:0] = shifted;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_spi_clk or posedge link_rst) begin
        if (link_rst) begin
            frame_reg <= '{bit_idx: 3'h0, byte_cnt: 3'h0, shift: 8'h00, mode: OUT_NONE}; // [RULE_07]
        end else begin
            frame_reg <= frame_next;
        end
    end

    always_ff @(posedge i_spi_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cap_reg <= '0;
        end else begin
            cap_reg <= cap_next;
        end
    end

    // Serial output, updated on the falling edge
    always_comb begin
        logic [7:0] id_byte;
        id_byte = 8'h00;
        unique case (frame_reg.byte_cnt)
            3'h1: id_byte = ID_WORD[23:16];
            3'h2: id_byte = ID_WORD[15:8];
            3'h3: id_byte = ID_WORD[7:0];
            default: id_byte = 8'h00;
        endcase
        out_next.q = 1'b0;
        out_next.oe_n = 1'b1;
        unique case (frame_reg.mode)
            OUT_STATUS: begin
                out_next.q = status_link[~frame_reg.bit_idx]; // [RULE_08] [RULE_24]
                out_next.oe_n = 1'b0;
            end
            OUT_IDENT: begin
                out_next.q = id_byte[~frame_reg.bit_idx]; // [RULE_04] [RULE_05]
                out_next.oe_n = 1'b0;
            end
            OUT_NONE: begin
            end
            default: begin
            end
        endcase
    end

    always_ff @(negedge i_spi_clk or posedge link_rst) begin
        if (link_rst) begin
            out_reg <= '{q: 1'b0, oe_n: 1'b1};
        end else begin
            out_reg <= out_next;
        end
    end

    assign o_spi_q = out_reg.q;
    assign o_spi_q_oe_n = out_reg.oe_n;

    // Protected-area check by sector
    function automatic logic in_protected(input logic [2:0] prot, input logic [23:0] addr);
        logic [6:0] limit;
        limit = SECTOR_COUNT - (7'h01 << (prot - 3'h1));
        in_protected = (prot != 3'h0) && ({1'b0, addr[23:18]} >= limit);
    endfunction

    // Command execution on the system clock
    always_comb begin
        logic hw_lock;
        logic frame_done;
        logic ok1;
        hw_lock = sys_reg.lock & ~wp_sys; // [RULE_14] [RULE_20] [RULE_21] [RULE_22]
        frame_done = cs_sys & ~sys_reg.cs_prev & (tog_sys != sys_reg.tog_seen);
        ok1 = cap_reg.aligned && cap_reg.bytes == BYTES_CMD_ONLY; // [RULE_02] [RULE_25]
        sys_next = sys_reg;
        sys_next.cs_prev = cs_sys;
        if (frame_done) begin
            sys_next.tog_seen = tog_sys;
        end
        unique case (sys_reg.state)
            SYS_IDLE: begin
                if (frame_done) begin
                    unique case (cap_reg.cmd)
                        CMD_WRITE_UNLOCK: begin
                            if (ok1) begin
                                sys_next.write_enable_latch = 1'b1; // [RULE_25]
                            end
                        end
                        CMD_WRITE_LOCK: begin
                            if (ok1) begin
                                sys_next.write_enable_latch = 1'b0; // [RULE_01] [RULE_03]
                            end
                        end
                        CMD_STATUS_WRITE: begin
                            if (cap_reg.aligned && cap_reg.bytes == BYTES_STATUS_WRITE && sys_reg.write_enable_latch
                                && !hw_lock) begin // [RULE_11] [RULE_14] [RULE_15] [RULE_16] [RULE_19]
                                sys_next.state = SYS_BUSY; // [RULE_18]
                                sys_next.pend_status = 1'b1;
                                sys_next.pend_lock = cap_reg.wdata[ST_LOCK_BIT];
                                sys_next.pend_prot = cap_reg.wdata[ST_PROT_MSB:ST_PROT_LSB];
                                sys_next.timer = STATUS_WRITE_CYC;
                            end
                        end
                        CMD_PAGE_PROGRAM: begin
                            if (cap_reg.aligned && cap_reg.bytes >= BYTES_PAGE_MIN && sys_reg.write_enable_latch
                                && !in_protected(sys_reg.prot, cap_reg.addr)) begin // [RULE_11] [RULE_12]
                                sys_next.state = SYS_BUSY;
                                sys_next.pend_status = 1'b0;
                                sys_next.timer = PAGE_PROGRAM_CYC;
                            end
                        end
                        CMD_SECTOR_ERASE: begin
                            if (cap_reg.aligned && cap_reg.bytes == BYTES_SECTOR_ERASE && sys_reg.write_enable_latch
                                && !in_protected(sys_reg.prot, cap_reg.addr)) begin // [RULE_12] [RULE_22]
                                sys_next.state = SYS_BUSY;
                                sys_next.pend_status = 1'b0;
                                sys_next.timer = SECTOR_ERASE_CYC;
                            end
                        end
                        CMD_BULK_ERASE: begin
                            if (ok1 && sys_reg.write_enable_latch && sys_reg.prot == 3'h0) begin // [RULE_13]
                                sys_next.state = SYS_BUSY;
                                sys_next.pend_status = 1'b0;
                                sys_next.timer = BULK_ERASE_CYC;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            SYS_BUSY: begin
                sys_next.timer = sys_reg.timer - 32'h1;
                if (sys_reg.timer <= 32'h1) begin
                    sys_next.state = SYS_IDLE;
                    sys_next.write_enable_latch = 1'b0; // [RULE_03] [RULE_18]
                    if (sys_reg.pend_status) begin
                        sys_next.lock = sys_reg.pend_lock; // [RULE_12] [RULE_17]
                        sys_next.prot = sys_reg.pend_prot;
                    end
                end
            end
            default: begin
                sys_next.state = SYS_IDLE;
            end
        endcase
        sys_next.status = 8'h00; // [RULE_17]
        sys_next.status[ST_LOCK_BIT] = sys_next.lock; // [RULE_26]
        sys_next.status[ST_PROT_MSB:ST_PROT_LSB] = sys_next.prot;
        sys_next.status[ST_WEL_BIT] = sys_next.write_enable_latch; // [RULE_11]
        sys_next.status[ST_BUSY_BIT] = (sys_next.state == SYS_BUSY); // [RULE_10]
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sys_reg <= '{state: SYS_IDLE, write_enable_latch: 1'b0, lock: NV_LOCK_RST, prot: NV_PROT_RST,
                         pend_status: 1'b0, pend_lock: 1'b0, pend_prot: 3'h0, timer: 32'h0,
                         cs_prev: 1'b0, tog_seen: 1'b0, status: 8'h00}; // [RULE_03]
        end else begin
            sys_reg <= sys_next;
        end
    end

    assign o_status_byte = sys_reg.status;
endmodule

// File: logic/fsp_pkg.sv
package fsp_pkg;
    // Command codes
    localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] CMD_WRITE_LOCK = 8'h04;
    localparam logic [7:0] CMD_IDENTITY_READ = 8'h9f;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'hd8;
    localparam logic [7:0] CMD_BULK_ERASE = 8'hc7;

    // Status byte layout
    localparam int ST_LOCK_BIT = 7;
    localparam int ST_ZERO_MSB = 6;
    localparam int ST_ZERO_LSB = 5;
    localparam int ST_PROT_MSB = 4;
    localparam int ST_PROT_LSB = 2;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_BUSY_BIT = 0;

    // Reset values
    localparam logic NV_LOCK_RST = 1'b0;
    localparam logic [2:0] NV_PROT_RST = 3'h0;

    // Frame byte counting; the counter stops at the largest value of interest
    localparam logic [2:0] BYTES_CMD_ONLY = 3'h1;
    localparam logic [2:0] BYTES_STATUS_WRITE = 3'h2;
    localparam logic [2:0] BYTES_SECTOR_ERASE = 3'h4;
    localparam logic [2:0] BYTES_PAGE_MIN = 3'h5;
    localparam logic [2:0] BYTES_SAT = 3'h5;
    localparam logic [2:0] BYTES_ID_LAST = 3'h3;
    localparam logic [6:0] SECTOR_COUNT = 7'h40;

    // Self-timed cycle durations
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int T_STATUS_WRITE_US = 5000;
    localparam int T_PAGE_PROGRAM_US = 2500;
    localparam int T_SECTOR_ERASE_US = 20000;
    localparam int T_BULK_ERASE_US = 50000;
    localparam int CYC_PER_US = SYS_CLK_HZ / 1_000_000;
    localparam int STATUS_WRITE_CYCLES = T_STATUS_WRITE_US * CYC_PER_US;
    localparam int PAGE_PROGRAM_CYCLES = T_PAGE_PROGRAM_US * CYC_PER_US;
    localparam int SECTOR_ERASE_CYCLES = T_SECTOR_ERASE_US * CYC_PER_US;
    localparam int BULK_ERASE_CYCLES = T_BULK_ERASE_US * CYC_PER_US;

    typedef enum logic [1:0] {
        SYS_IDLE = 2'b01,
        SYS_BUSY = 2'b10
    } fsp_sys_e;

    typedef enum logic [2:0] {
        OUT_NONE = 3'b001,
        OUT_STATUS = 3'b010,
        OUT_IDENT = 3'b100
    } fsp_out_e;
endpackage

// File: logic/fsp_sync.sv
`timescale 1ns/1ps
module fsp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] q;
    } fsp_sync_s;

    fsp_sync_s state_reg;
    fsp_sync_s state_next;

    always_comb begin
        state_next.meta = i_d;
        state_next.q = state_reg.meta;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_q = state_reg.q;
endmodule

// File: tb/fsp_top_sva.sv
`timescale 1ns/1ps
module fsp_top_sva #(
    parameter int unsigned STATUS_WRITE_CYC = 20,
    parameter int unsigned PAGE_PROGRAM_CYC = 20,
    parameter int unsigned SECTOR_ERASE_CYC = 20,
    parameter int unsigned BULK_ERASE_CYC = 20
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_spi_clk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_d,
    input wire logic i_wp_n,
    input wire logic o_spi_q,
    input wire logic o_spi_q_oe_n,
    input wire logic [7:0] o_status_byte
);
    logic cs_q;
    logic [3:0] since_rise;
    int unsigned busy_cnt;

    // Cycles since chip select last rose, and length of the running busy period
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cs_q <= 1'b1;
            since_rise <= 4'hf;
            busy_cnt <= 0;
        end else begin
            cs_q <= i_spi_cs_n;
            if (i_spi_cs_n && !cs_q) since_rise <= 4'h0;
            else if (since_rise != 4'hf) since_rise <= since_rise + 4'h1;
            busy_cnt <= o_status_byte[0] ? busy_cnt + 1 : 0;
        end
    end

    function automatic logic near(input int unsigned c, input int unsigned p);
        return (c + 2 >= p) && (c <= p + 2);
    endfunction

    sequence s_recent_frame;
        since_rise <= 4'h6;
    endsequence
    sequence s_cycle_end;
        $fell(o_status_byte[0]);
    endsequence

    a_idle_no_drive: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        i_spi_cs_n |-> o_spi_q_oe_n) else $error("output enabled while deselected");
    a_idle_q_low: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_spi_q_oe_n |-> !o_spi_q) else $error("serial output not low while released");
    a_zero_bits: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_status_byte[6:5] == 2'b00) else $error("status bits 6..5 not zero");
    a_wel_cycle_end: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        s_cycle_end |-> !o_status_byte[1]) else $error("latch still set at cycle end");
    a_nv_change_end: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !$stable({o_status_byte[7], o_status_byte[4:2]}) |-> s_cycle_end) else $error("lock bits changed midway");
    a_hpm_frozen: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_status_byte[7] && !o_status_byte[0] && !i_wp_n && $past(!i_wp_n, 8))
        |=> $stable(o_status_byte[7:2])) else $error("status changed in hardware lock");
    a_busy_length: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        s_cycle_end |-> near(busy_cnt, STATUS_WRITE_CYC) || near(busy_cnt, PAGE_PROGRAM_CYC)
        || near(busy_cnt, SECTOR_ERASE_CYC) || near(busy_cnt, BULK_ERASE_CYC)) else $error("busy length wrong");
    a_wel_after_frame: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(o_status_byte[1]) |-> s_recent_frame) else $error("latch set without a frame");
    a_busy_after_frame: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(o_status_byte[0]) |-> s_recent_frame) else $error("busy started without a frame");
    a_busy_needs_wel: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(o_status_byte[0]) |-> $past(o_status_byte[1])) else $error("cycle started with latch clear");
endmodule

bind fsp_top fsp_top_sva #(.STATUS_WRITE_CYC(STATUS_WRITE_CYC), .PAGE_PROGRAM_CYC(PAGE_PROGRAM_CYC),
    .SECTOR_ERASE_CYC(SECTOR_ERASE_CYC), .BULK_ERASE_CYC(BULK_ERASE_CYC)) i_sva (.i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst), .i_spi_clk(i_spi_clk), .i_spi_cs_n(i_spi_cs_n), .i_spi_d(i_spi_d), .i_wp_n(i_wp_n),
    .o_spi_q(o_spi_q), .o_spi_q_oe_n(o_spi_q_oe_n), .o_status_byte(o_status_byte));

// File: tb/fsp_host_model.sv
`timescale 1ns/1ps
module fsp_host_model (
    output logic o_spi_clk,
    output logic o_spi_cs_n,
    output logic o_spi_d,
    input wire logic i_spi_q
);
    initial begin
        o_spi_clk = 1'b0;
        o_spi_cs_n = 1'b1;
        o_spi_d = 1'b0;
    end

    // One framed transfer; the serial clock stands low outside frames
    task automatic frame(input logic [39:0] tx, input int n_bits, output logic [39:0] rx);
        rx = '0;
        #13;
        o_spi_cs_n = 1'b0;
        for (int i = n_bits - 1; i >= 0; i--) begin
            o_spi_d = tx[i];
            #62.5;
            o_spi_clk = 1'b1;
            rx = {rx[38:0], i_spi_q};
            #62.5;
            o_spi_clk = 1'b0;
        end
        #30;
        o_spi_cs_n = 1'b1;
        o_spi_d = ~o_spi_d;
        #300;
    endtask
endmodule

// File: tb/fsp_top_tb_top.sv
`timescale 1ns/1ps
module fsp_top_tb_top;
    import fsp_pkg::*;
    localparam logic [23:0] ID = 24'hc3619e; // Arbitrary identification value
    logic i_clk_sys, i_sys_rst, i_wp_n, spi_clk, spi_cs_n, spi_d, o_spi_q, o_spi_q_oe_n;
    logic [7:0] o_status_byte;
    logic [39:0] rx;
    int n_errors = 0;
    int compares = 0;

    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    fsp_top #(.ID_WORD(ID), .STATUS_WRITE_CYC(200), .PAGE_PROGRAM_CYC(400), .SECTOR_ERASE_CYC(20),
        .BULK_ERASE_CYC(20)) i_dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_spi_clk(spi_clk),
        .i_spi_cs_n(spi_cs_n), .i_spi_d(spi_d), .i_wp_n(i_wp_n), .o_spi_q(o_spi_q),
        .o_spi_q_oe_n(o_spi_q_oe_n), .o_status_byte(o_status_byte));
    fsp_host_model i_host (.o_spi_clk(spi_clk), .o_spi_cs_n(spi_cs_n), .o_spi_d(spi_d), .i_spi_q(o_spi_q));

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] c);
        i_host.frame({32'h0, c}, 8, rx);
    endtask

    // Unlock, then a status write cut to n_bits
    task automatic wr_status(input logic [7:0] v, input int n_bits);
        cmd(CMD_WRITE_UNLOCK);
        i_host.frame({24'h0, CMD_STATUS_WRITE, v} >> (16 - n_bits), n_bits, rx);
    endtask

    // Status on the port and twice over the link
    task automatic expect_status(input logic [7:0] exp);
        repeat (10) @(negedge i_clk_sys);
        check({24'h0, o_status_byte}, {24'h0, exp});
        i_host.frame({16'h0, CMD_STATUS_READ, 16'h0}, 24, rx);
        check({16'h0, rx[15:0]}, {16'h0, exp, exp});
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (o_status_byte[0] !== 1'b0 && n < 2000) begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n >= 2000) begin
            n_errors++;
            $display("Error at %0t: busy never cleared", $time);
            complete_run();
        end
    endtask

    task automatic set_wp(input logic v);
        @(negedge i_clk_sys);
        i_wp_n = v;
    endtask

    initial begin
        #2ms;
        n_errors++;
        $display("Error at %0t: run timed out", $time);
        complete_run();
    end

    initial begin
        i_sys_rst = 1'b1;
        i_wp_n = 1'b1;
        repeat (20) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        expect_status(8'h00);
        cmd(CMD_WRITE_UNLOCK);
        expect_status(8'h02);
        cmd(CMD_WRITE_LOCK);
        expect_status(8'h00);
        wr_status(8'hff, 15);
        expect_status(8'h02);
        cmd(CMD_WRITE_LOCK);
        i_host.frame({24'h0, CMD_STATUS_WRITE, 8'hff}, 16, rx);
        expect_status(8'h00);
        wr_status(8'hff, 16);
        expect_status(8'h03);
        wait_idle();
        expect_status(8'h9c);
        cmd(CMD_WRITE_UNLOCK);
        cmd(CMD_BULK_ERASE);
        expect_status(8'h9e);
        cmd(CMD_WRITE_LOCK);
        set_wp(1'b0);
        wr_status(8'h00, 16);
        expect_status(8'h9e);
        cmd(CMD_WRITE_LOCK);
        set_wp(1'b1);
        wr_status(8'h00, 16);
        wait_idle();
        expect_status(8'h00);
        set_wp(1'b0);
        wr_status(8'h84, 16);
        wait_idle();
        expect_status(8'h84);
        wr_status(8'h00, 16);
        expect_status(8'h86);
        i_host.frame({CMD_PAGE_PROGRAM, 24'hfc0000, 8'h5a}, 40, rx);
        expect_status(8'h86);
        cmd(CMD_WRITE_LOCK);
        set_wp(1'b1);
        wr_status(8'h00, 16);
        wait_idle();
        cmd(CMD_WRITE_UNLOCK);
        i_host.frame({CMD_PAGE_PROGRAM, 24'h000000, 8'ha5}, 40, rx);
        i_host.frame({8'h0, CMD_IDENTITY_READ, 24'h0}, 32, rx);
        check(rx[31:0], 32'h0);
        check({31'h0, o_status_byte[0]}, 32'h1);
        wait_idle();
        expect_status(8'h00);
        i_host.frame({8'h0, CMD_IDENTITY_READ, 24'h0}, 32, rx);
        check({8'h0, rx[23:0]}, {8'h0, ID});
        i_host.frame({20'h0, CMD_IDENTITY_READ, 12'h0}, 20, rx);
        check({20'h0, rx[11:0]}, {20'h0, ID[23:12]});
        check({31'h0, o_spi_q_oe_n}, 32'h1);
        expect_status(8'h00);
        cmd(CMD_WRITE_UNLOCK);
        i_host.frame({8'h0, CMD_SECTOR_ERASE, 24'h040000}, 32, rx);
        check({31'h0, o_status_byte[0]}, 32'h1);
        wait_idle();
        cmd(CMD_WRITE_UNLOCK);
        cmd(CMD_BULK_ERASE);
        check({31'h0, o_status_byte[0]}, 32'h1);
        wait_idle();
        expect_status(8'h00);
        complete_run();
    end
endmodule
